/* File: src/acc_pkg.sv */
package acc_pkg;
   localparam int          ACC_UNITS        = 3;
   localparam int          ACC_PAGE_W       = 8;
   localparam int          ACC_ADDR_W       = 8;
   // Special-function-register offsets; unit chosen by page
   localparam logic [7:0]  ACC_CTRL_ADDR    = 8'h88;
   localparam logic [7:0]  ACC_MODE_ADDR    = 8'h89;
   localparam logic [7:0]  ACC_PAGE_BASE    = 8'h01;
   // Control register fields
   localparam int          ACC_EN_BIT       = 7;
   localparam int          ACC_OUT_BIT      = 6;
   localparam int          ACC_RIF_BIT      = 5;
   localparam int          ACC_FIF_BIT      = 4;
   localparam int          ACC_HYP_LSB      = 2;
   localparam int          ACC_HYN_LSB      = 0;
   localparam logic [7:0]  ACC_CTRL_RESET   = 8'h00;
   // Mode register fields
   localparam int          ACC_RIE_BIT      = 5;
   localparam int          ACC_FIE_BIT      = 4;
   localparam int          ACC_MD_LSB       = 0;
   localparam logic [7:0]  ACC_MODE_RESET   = 8'h02;
   localparam logic [7:0]  ACC_MODE_WMASK   = 8'h33;
   // Hysteresis settings
   typedef enum logic [1:0] {
      ACC_HYS_OFF = 2'h0,
      ACC_HYS_5MV = 2'h1,
      ACC_HYS_10MV = 2'h2,
      ACC_HYS_20MV = 2'h3
   } acc_hys_t;
endpackage

/* File: src/acc_sync.sv */
`timescale 1ns/100ps
// Three-stage synchroniser; output moves only when stages two and three agree
module acc_sync
   import acc_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic srst,
   // Asynchronous level in, clean level out
   input  wire logic async_in,
   output logic      sync_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync_out <= 1'b0;
      end else if (s2_reg == s3_reg) begin
         sync_out <= s3_reg;
      end
   end
endmodule

/* File: src/acc_top.sv */
`timescale 1ns/100ps
//
// Contract
// - Each comparator enables independently.
// - Disabled comparator drives port output low.
// - Control bit 7 turns comparator on/off.
// - Control bit 6 reads live result.
// - Falling edge sets control bit 4.
// - Rising edge sets control bit 5.
// - Edge interrupts gated by mode enables.
// - Interrupt also needs extended enable bit.
// - Hysteresis from control bits 3-0.
// - Negative hysteresis: off, 5, 10, 20 mV.
// - Positive hysteresis selected independently likewise.
// - Mode bits 1-0 drive response time.
// - Output usable everywhere at once.
// - Mode bits 5,4,1-0; reset 00000010.
//
module acc_top
   import acc_pkg::*;
(
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   // Special-function-register bus
   input  wire logic [ACC_ADDR_W-1:0] sfr_addr,
   input  wire logic [ACC_PAGE_W-1:0] sfr_page,
   input  wire logic [7:0]            sfr_wdata,
   input  wire logic                  sfr_wr,
   input  wire logic                  sfr_rd,
   output logic      [7:0]            sfr_rdata,
   // Extended interrupt enable bits, one per comparator
   input  wire logic [ACC_UNITS-1:0]  ext_irq_enable,
   // Analog comparator cores
   input  wire logic [ACC_UNITS-1:0]  cmp_raw,
   output logic      [ACC_UNITS-1:0]  cmp_enable,
   output logic      [1:0]            cmp_pos_hysteresis [ACC_UNITS],
   output logic      [1:0]            cmp_neg_hysteresis [ACC_UNITS],
   output logic      [1:0]            cmp_response_mode  [ACC_UNITS],
   // Crossbar, reset source and interrupt
   output logic      [ACC_UNITS-1:0]  cmp_port_out,
   output logic      [ACC_UNITS-1:0]  cmp_reset_src,
   output logic      [ACC_UNITS-1:0]  cmp_irq
);
   // ------------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------------
   // Unit select: 1 for a hit on the given unit's page and address
   function automatic logic hit(input logic [7:0] a, input logic [7:0] p,
                                input logic [7:0] reg_addr, input int unit);
      hit = (a == reg_addr) && (p == ACC_PAGE_BASE + 8'(unit));
   endfunction

   // ------------------------------------------------------------------
   // Shared state
   // ------------------------------------------------------------------
   logic [7:0]           ctrl_reg [ACC_UNITS];
   logic [7:0]           mode_reg [ACC_UNITS];
   logic [ACC_UNITS-1:0] sync_out;
   logic [ACC_UNITS-1:0] prev_reg;
   logic [7:0]           rdata_next;

   genvar g;
   // One slice per comparator; slices share only the bus
   generate
      for (g = 0; g < ACC_UNITS; g++) begin : g_unit
         logic live;
         logic rise;
         logic fall;
         logic ctrl_wr;
         logic mode_wr;
         logic rise_req;
         logic fall_req;

         // ------------------------------------------------------------
         // Input synchroniser
         // ------------------------------------------------------------
         acc_sync u_sync (
            .sys_clk  (sys_clk),
            .srst     (srst),
            .async_in (cmp_raw[g]),
            .sync_out (sync_out[g])
         );

         // ------------------------------------------------------------
         // Edge detection
         // ------------------------------------------------------------
         // Disabled core reads as low everywhere, so no edge leaks through
         // Enabling while the input is high reports a rise, by design
         assign live = sync_out[g] & ctrl_reg[g][ACC_EN_BIT];
         assign rise = ~prev_reg[g] & live;
         assign fall = prev_reg[g] & ~live;

         always_ff @(posedge sys_clk) begin
            if (srst) begin
               prev_reg[g] <= 1'b0;
            end else begin
               prev_reg[g] <= live;
            end
         end

         // ------------------------------------------------------------
         // Write decode
         // ------------------------------------------------------------
         assign ctrl_wr = sfr_wr && hit(sfr_addr, sfr_page, ACC_CTRL_ADDR, g);
         assign mode_wr = sfr_wr && hit(sfr_addr, sfr_page, ACC_MODE_ADDR, g);

         // ------------------------------------------------------------
         // Control register
         // ------------------------------------------------------------
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               ctrl_reg[g] <= ACC_CTRL_RESET;
            end else begin
               if (ctrl_wr) begin
                  ctrl_reg[g][ACC_EN_BIT]              <= sfr_wdata[ACC_EN_BIT];
                  ctrl_reg[g][ACC_RIF_BIT]             <= sfr_wdata[ACC_RIF_BIT];
                  ctrl_reg[g][ACC_FIF_BIT]             <= sfr_wdata[ACC_FIF_BIT];
                  ctrl_reg[g][ACC_HYP_LSB+1:ACC_HYP_LSB] <= sfr_wdata[ACC_HYP_LSB+1:ACC_HYP_LSB];
                  ctrl_reg[g][ACC_HYN_LSB+1:ACC_HYN_LSB] <= sfr_wdata[ACC_HYN_LSB+1:ACC_HYN_LSB];
               end
               ctrl_reg[g][ACC_OUT_BIT] <= live;
               // Hardware set placed last so it beats a same-cycle clear
               if (rise) begin
                  ctrl_reg[g][ACC_RIF_BIT] <= 1'b1;
               end
               if (fall) begin
                  ctrl_reg[g][ACC_FIF_BIT] <= 1'b1;
               end
            end
         end

         // ------------------------------------------------------------
         // Mode register
         // ------------------------------------------------------------
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               mode_reg[g] <= ACC_MODE_RESET;
            end else if (mode_wr) begin
               // Unused bits read back as zero
               mode_reg[g] <= sfr_wdata & ACC_MODE_WMASK;
            end
         end

         // ------------------------------------------------------------
         // Outputs to the analog core
         // ------------------------------------------------------------
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               cmp_enable[g]         <= 1'b0;
               cmp_pos_hysteresis[g] <= ACC_HYS_OFF;
               cmp_neg_hysteresis[g] <= ACC_HYS_OFF;
               cmp_response_mode[g]  <= ACC_MODE_RESET[ACC_MD_LSB+1:ACC_MD_LSB];
            end else begin
               cmp_enable[g]         <= ctrl_reg[g][ACC_EN_BIT];
               cmp_pos_hysteresis[g] <= ctrl_reg[g][ACC_HYP_LSB+1:ACC_HYP_LSB];
               cmp_neg_hysteresis[g] <= ctrl_reg[g][ACC_HYN_LSB+1:ACC_HYN_LSB];
               cmp_response_mode[g]  <= mode_reg[g][ACC_MD_LSB+1:ACC_MD_LSB];
            end
         end

         // ------------------------------------------------------------
         // Crossbar and reset source
         // ------------------------------------------------------------
         // Reset source shares the port value; no extra filtering
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               cmp_port_out[g]  <= 1'b0;
               cmp_reset_src[g] <= 1'b0;
            end else begin
               cmp_port_out[g]  <= live;
               cmp_reset_src[g] <= live;
            end
         end

         // ------------------------------------------------------------
         // Interrupt request
         // ------------------------------------------------------------
         assign rise_req = ctrl_reg[g][ACC_RIF_BIT] & mode_reg[g][ACC_RIE_BIT];
         assign fall_req = ctrl_reg[g][ACC_FIF_BIT] & mode_reg[g][ACC_FIE_BIT];
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               cmp_irq[g] <= 1'b0;
            end else begin
               // Level request follows the sticky flags until software clears them
               cmp_irq[g] <= ext_irq_enable[g] & (rise_req | fall_req);
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   // Pages never overlap, so at most one hit per access
   always_comb begin
      rdata_next = 8'h00;
      for (int u = 0; u < ACC_UNITS; u++) begin
         if (hit(sfr_addr, sfr_page, ACC_CTRL_ADDR, u)) begin
            rdata_next = ctrl_reg[u];
         end
         if (hit(sfr_addr, sfr_page, ACC_MODE_ADDR, u)) begin
            rdata_next = mode_reg[u];
         end
      end
   end

   // ------------------------------------------------------------------
   // Read data register
   // ------------------------------------------------------------------
   // Registered read data: valid the cycle after sfr_rd
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= rdata_next;
      end
   end
endmodule

/* File: sim/acc_top_assertions.sv */
`timescale 1ns/100ps
module acc_chk
   import acc_pkg::*;
(
   // Clock, reset and bus
   input wire logic       sys_clk,
   input wire logic       srst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   // Comparator side
   input wire logic [2:0] ext_irq_enable,
   input wire logic [2:0] cmp_raw,
   input wire logic [2:0] cmp_enable,
   input wire logic [1:0] cmp_response_mode [ACC_UNITS],
   input wire logic [2:0] cmp_port_out,
   input wire logic [2:0] cmp_reset_src,
   input wire logic [2:0] cmp_irq
);
   // ---
   // Unit 0 properties, with all-unit reset-mirror and after-reset enable checks
   // ---
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   wire w0 = sfr_wr && sfr_page == ACC_PAGE_BASE && sfr_addr == ACC_CTRL_ADDR;
   chk_enable_on: assert property (w0 && sfr_wdata[7] |-> ##[1:2] cmp_enable[0])
      else $error("enable not set by write");
   chk_enable_off: assert property (w0 && !sfr_wdata[7] |-> ##[1:2] !cmp_enable[0])
      else $error("enable not cleared by write");
   chk_port_low: assert property (!cmp_enable[0] && !$past(cmp_enable[0]) |-> !cmp_port_out[0])
      else $error("port output high while disabled");
   chk_reset_mirror: assert property (cmp_reset_src == cmp_port_out)
      else $error("reset source differs from port output");
   chk_irq_gate: assert property (!ext_irq_enable[0] |=> !cmp_irq[0])
      else $error("interrupt without extended enable");
   chk_sync_delay: assert property ($rose(cmp_port_out[0]) |-> $past(cmp_raw[0], 2) && $past(cmp_raw[0], 3))
      else $error("output rose before input settled");
   chk_mode_reset: assert property ($past(srst) |-> cmp_response_mode[0] == 2'h2 && cmp_enable == 3'h0)
      else $error("wrong value after reset");
   chk_read_hold: assert property (!sfr_rd && !$past(sfr_rd) |=> $stable(sfr_rdata))
      else $error("read data moved without a read");
endmodule
bind acc_top acc_chk u_acc_chk (.*);

/* File: sim/acc_cmp_model.sv */
`timescale 1ns/100ps
module acc_cmp_model
   import acc_pkg::*;
#(
   parameter int PWRUP = 6
)
(
   input wire logic [ACC_UNITS-1:0] cmp_enable,
   input wire logic                 sys_clk,
   input wire logic [ACC_UNITS-1:0] level,
   output logic     [ACC_UNITS-1:0] cmp_raw
);
   int   wait_cnt [ACC_UNITS];
   logic flip = 1'b0;
   // Shut-down or settling core gives garbage, not the last level
   always_ff @(posedge sys_clk) begin
      flip <= !flip;
      for (int i = 0; i < ACC_UNITS; i++) begin
         if (!cmp_enable[i]) wait_cnt[i] <= PWRUP;
         else if (wait_cnt[i] != 0) wait_cnt[i] <= wait_cnt[i] - 1;
      end
   end
   always_comb begin
      for (int i = 0; i < ACC_UNITS; i++) cmp_raw[i] = (cmp_enable[i] && wait_cnt[i] == 0) ? level[i] : flip;
   end
endmodule

/* File: sim/analog_comparator_control_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s %h %h", nm, e, g); end end
module analog_comparator_control_tb
   import acc_pkg::*;
;
   logic       sys_clk = 1'b0, srst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic [2:0] ext_irq_enable = 3'h0, level = 3'h0, cmp_raw, cmp_enable, cmp_port_out, cmp_reset_src, cmp_irq;
   logic [1:0] cmp_pos_hysteresis [ACC_UNITS], cmp_neg_hysteresis [ACC_UNITS], cmp_response_mode [ACC_UNITS];
   int         fails = 0, n_checks = 0, cycles = 0;
   acc_top u_acc_top (.*);
   acc_cmp_model u_acc_cmp_model (.*);
   initial forever #50 sys_clk = !sys_clk;
   // ---
   // Bus tasks
   // ---
   task automatic wr(input logic [7:0] pg, ad, d);
      @(negedge sys_clk);
      sfr_page = pg;
      sfr_addr = ad;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] pg, ad, e);
      @(negedge sys_clk);
      sfr_page = pg;
      sfr_addr = ad;
      sfr_rd = 1'b1;
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      @(negedge sys_clk);
      `CHK("sfr_rdata", e, sfr_rdata)
   endtask
   task automatic finish_test();
      if (fails == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         finish_test();
      end
   end
   initial begin
      repeat (10) @(negedge sys_clk);
      srst = 1'b0;
      rd(8'h01, ACC_CTRL_ADDR, 8'h00);
      rd(8'h03, ACC_MODE_ADDR, 8'h02);
      rd(8'h01, 8'h90, 8'h00);
      // Only unit 1 on: units must not follow each other
      wr(8'h02, ACC_CTRL_ADDR, 8'h80);
      repeat (3) @(negedge sys_clk);
      `CHK("cmp_enable", 3'b010, cmp_enable)
      for (int h = 0; h < 4; h++) begin
         wr(8'h03, ACC_CTRL_ADDR, 8'(h * 4 + 3 - h));
         repeat (3) @(negedge sys_clk);
         `CHK("pos_hys", 2'(h), cmp_pos_hysteresis[2])
         `CHK("neg_hys", 2'(3 - h), cmp_neg_hysteresis[2])
      end
      wr(8'h03, ACC_CTRL_ADDR, 8'h49);
      rd(8'h03, ACC_CTRL_ADDR, 8'h09);
      ext_irq_enable = 3'b001;
      wr(8'h01, ACC_MODE_ADDR, 8'hFF);
      rd(8'h01, ACC_MODE_ADDR, 8'h33);
      `CHK("resp_mode", 2'h3, cmp_response_mode[0])
      wr(8'h01, ACC_CTRL_ADDR, 8'h80);
      // Power-up garbage may set flags, so clear them after settling
      repeat (12) @(negedge sys_clk);
      wr(8'h01, ACC_CTRL_ADDR, 8'h80);
      level[0] = 1'b1;
      repeat (8) @(negedge sys_clk);
      `CHK("port_out", 3'b001, cmp_port_out)
      `CHK("reset_src", 3'b001, cmp_reset_src)
      `CHK("irq_rise", 3'b001, cmp_irq)
      rd(8'h01, ACC_CTRL_ADDR, 8'hE0);
      ext_irq_enable = 3'b000;
      repeat (2) @(negedge sys_clk);
      `CHK("irq_masked", 3'b000, cmp_irq)
      ext_irq_enable = 3'b001;
      level[0] = 1'b0;
      repeat (8) @(negedge sys_clk);
      rd(8'h01, ACC_CTRL_ADDR, 8'hB0);
      wr(8'h01, ACC_CTRL_ADDR, 8'h80);
      repeat (2) @(negedge sys_clk);
      `CHK("irq_clear", 3'b000, cmp_irq)
      rd(8'h01, ACC_CTRL_ADDR, 8'h80);
      level[0] = 1'b1;
      repeat (8) @(negedge sys_clk);
      wr(8'h01, ACC_CTRL_ADDR, 8'h00);
      repeat (3) @(negedge sys_clk);
      `CHK("port_low", 3'b000, cmp_port_out)
      finish_test();
   end
endmodule
